//--- src/bomc_cfg.sv
// binary output message configuration register with write checks and pacing
`include "bomc_map.svh"

module bomc_cfg (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic                ce_i,
    // register write from the command link
    input  wire logic                wr_start_i,
    input  wire logic [7:0]          wr_reg_id_i,
    input  wire logic                wr_byte_valid_i,
    input  wire logic [7:0]          wr_byte_i,
    input  wire logic                wr_byte_last_i,
    // write response
    output logic                     resp_valid_o,
    output bomc_pkg::bomc_resp_t     resp_code_o,
    // register read to the command link
    input  wire logic                rd_start_i,
    input  wire logic [7:0]          rd_reg_id_i,
    input  wire logic                rd_byte_ready_i,
    output logic                     rd_byte_valid_o,
    output logic [7:0]               rd_byte_o,
    output logic                     rd_byte_last_o,
    // current baud capacity, bytes per second
    input  wire logic [23:0]         baud_bytes_per_s_i,
    // inertial sample pulse and emission
    input  wire logic                imu_tick_i,
    output logic                     emit_port1_o,
    output logic                     emit_port2_o,
    // active configuration to the emitter
    output logic [15:0]              output_port_select_o,
    output logic [15:0]              emit_rate_divider_o,
    output logic [15:0]              group_select_mask_o,
    output logic [3:0]               field_count_o,
    input  wire logic [2:0]          field_rd_idx_i,
    output logic [15:0]              field_select_word_o
);

    // staging buffer for the incoming payload and the committed image
    logic [7:0]            stg_reg [0:21];
    logic [7:0]            img_reg [0:21];
    logic [4:0]            stg_len_reg;
    logic                  stg_ovf_reg;
    logic [4:0]            img_len_reg;
    logic [4:0]            rd_idx_reg;
    bomc_pkg::bomc_state_t state_reg;
    logic                  emit_reg;

    // decoded check terms on the staging buffer
    logic                  chk_two_bytes;
    logic [15:0]           chk_mask;
    logic [4:0]            chk_groups;
    logic [4:0]            chk_rem;
    logic [4:0]            chk_fields;
    logic [15:0]           chk_div;
    logic [15:0]           chk_port;
    logic [15:0]           chk_field_bits;
    logic [15:0]           chk_est_bytes;
    logic [47:0]           chk_need;
    logic [47:0]           chk_have;
    logic                  chk_len_ok;
    logic                  chk_param_ok;
    logic                  chk_baud_ok;

    // set bits of a 16-bit word
    function automatic logic [4:0] bomc_popcount(input logic [15:0] w);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            c = c + {4'h0, w[i]};
        end
        return c;
    endfunction

    assign chk_two_bytes = stg_reg[4][`BOMC_GROUP_EXT_BIT];
    assign chk_mask = chk_two_bytes ? {stg_reg[5], stg_reg[4]} : {8'h00, stg_reg[4]};
    // the extension bit marks the second byte and selects no group itself
    assign chk_groups = bomc_popcount(chk_mask) - {4'h0, chk_two_bytes};
    assign chk_rem    = stg_len_reg - 5'h04 - (chk_two_bytes ? 5'h02 : 5'h01);
    assign chk_fields = {1'b0, chk_rem[4:1]};
    assign chk_port   = {stg_reg[1], stg_reg[0]};
    assign chk_div    = {stg_reg[3], stg_reg[2]};

    assign chk_len_ok = !stg_ovf_reg
                        && stg_len_reg >= `BOMC_LEN_MIN
                        && stg_len_reg <= `BOMC_LEN_MAX
                        && stg_len_reg >= (chk_two_bytes ? 5'h06 : 5'h05);

    assign chk_param_ok = chk_len_ok
                          && !chk_rem[0]
                          && chk_fields == chk_groups
                          && chk_port <= `BOMC_PORT_BOTH
                          && chk_div != 16'h0000;

    // total selected fields over the staged field words
    always_comb
    begin
        chk_field_bits = 16'h0000;
        for (int k = 0; k < `BOMC_MAX_FIELDS; k++)
        begin
            if (k < 32'(chk_fields))
            begin
                chk_field_bits = chk_field_bits + {11'h000, bomc_popcount(
                    {stg_reg[(chk_two_bytes ? 7 : 6) + 2 * k],
                     stg_reg[(chk_two_bytes ? 6 : 5) + 2 * k]})};
            end
        end
    end

    // estimate of bytes per message; the real frame layout is the emitter's
    assign chk_est_bytes = `BOMC_MSG_OVERHEAD + 16'(chk_field_bits * `BOMC_BYTES_PER_FIELD);

    assign chk_need = 48'(chk_est_bytes) * 48'(`BOMC_IMU_RATE_HZ);
    assign chk_have = 48'(baud_bytes_per_s_i) * 48'(chk_div);
    // disabled output needs no bandwidth
    assign chk_baud_ok = (chk_port == `BOMC_PORT_NONE) || (chk_need <= chk_have);

    // transaction sequencing: write receive, check, read stream
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg <= bomc_pkg::BOMC_ST_IDLE;
        end
        else if (ce_i)
        begin
            case (state_reg)
                bomc_pkg::BOMC_ST_IDLE:
                begin
                    if (wr_start_i && wr_reg_id_i == `BOMC_REG_ID)
                    begin
                        state_reg <= bomc_pkg::BOMC_ST_RECV;
                    end
                    else if (rd_start_i && rd_reg_id_i == `BOMC_REG_ID)
                    begin
                        state_reg <= bomc_pkg::BOMC_ST_READ;
                    end
                end
                bomc_pkg::BOMC_ST_RECV:
                begin
                    if (wr_byte_valid_i && wr_byte_last_i)
                    begin
                        state_reg <= bomc_pkg::BOMC_ST_CHECK;
                    end
                end
                bomc_pkg::BOMC_ST_CHECK:
                begin
                    state_reg <= bomc_pkg::BOMC_ST_IDLE;
                end
                bomc_pkg::BOMC_ST_READ:
                begin
                    if (rd_byte_ready_i && rd_idx_reg == img_len_reg - 5'h01)
                    begin
                        state_reg <= bomc_pkg::BOMC_ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= bomc_pkg::BOMC_ST_IDLE;
                end
            endcase
        end
    end

    // staging buffer fill; bytes past the maximum only raise overflow
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stg_len_reg <= 5'h00;
            stg_ovf_reg <= 1'b0;
            for (int i = 0; i < 22; i++)
            begin
                stg_reg[i] <= 8'h00;
            end
        end
        else if (ce_i)
        begin
            if (state_reg == bomc_pkg::BOMC_ST_IDLE)
            begin
                stg_len_reg <= 5'h00;
                stg_ovf_reg <= 1'b0;
            end
            else if (state_reg == bomc_pkg::BOMC_ST_RECV && wr_byte_valid_i)
            begin
                if (stg_len_reg < `BOMC_LEN_MAX)
                begin
                    stg_reg[stg_len_reg] <= wr_byte_i;
                    stg_len_reg          <= stg_len_reg + 5'h01;
                end
                else
                begin
                    stg_ovf_reg <= 1'b1;
                end
            end
        end
    end

    // commit the staged image only when every check passes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            img_len_reg <= `BOMC_RST_LEN;
            for (int i = 0; i < 22; i++)
            begin
                img_reg[i] <= 8'h00;
            end
            img_reg[0] <= 8'(`BOMC_RST_PORT_SEL & 16'h00FF);
            img_reg[1] <= 8'(`BOMC_RST_PORT_SEL >> 8);
            img_reg[2] <= 8'(`BOMC_RST_RATE_DIV & 16'h00FF);
            img_reg[3] <= 8'(`BOMC_RST_RATE_DIV >> 8);
            img_reg[4] <= `BOMC_RST_GROUP;
        end
        else if (ce_i && state_reg == bomc_pkg::BOMC_ST_CHECK && chk_param_ok && chk_baud_ok)
        begin
            img_len_reg <= stg_len_reg;
            for (int i = 0; i < 22; i++)
            begin
                img_reg[i] <= (5'(i) < stg_len_reg) ? stg_reg[i] : 8'h00;
            end
        end
    end

    // one response per write; parameter errors take priority over baud
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            resp_valid_o <= 1'b0;
            resp_code_o  <= bomc_pkg::BOMC_RESP_OK;
        end
        else if (ce_i)
        begin
            resp_valid_o <= state_reg == bomc_pkg::BOMC_ST_CHECK;
            if (state_reg == bomc_pkg::BOMC_ST_CHECK)
            begin
                if (!chk_param_ok)
                begin
                    resp_code_o <= bomc_pkg::BOMC_RESP_INVALID_PARAM;
                end
                else if (!chk_baud_ok)
                begin
                    resp_code_o <= bomc_pkg::BOMC_RESP_INSUFF_BAUD;
                end
                else
                begin
                    resp_code_o <= bomc_pkg::BOMC_RESP_OK;
                end
            end
        end
    end

    // read stream index; held while the link stalls
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_idx_reg <= 5'h00;
        end
        else if (ce_i)
        begin
            if (state_reg != bomc_pkg::BOMC_ST_READ)
            begin
                rd_idx_reg <= 5'h00;
            end
            else if (rd_byte_ready_i)
            begin
                rd_idx_reg <= rd_idx_reg + 5'h01;
            end
        end
    end

    assign rd_byte_valid_o = state_reg == bomc_pkg::BOMC_ST_READ;
    assign rd_byte_o       = rd_byte_valid_o ? img_reg[rd_idx_reg] : 8'h00;
    assign rd_byte_last_o  = rd_byte_valid_o && rd_idx_reg == img_len_reg - 5'h01;

    // active configuration fields from the committed image
    assign output_port_select_o = {img_reg[1], img_reg[0]};
    assign emit_rate_divider_o  = {img_reg[3], img_reg[2]};
    assign group_select_mask_o  = img_reg[4][`BOMC_GROUP_EXT_BIT] ?
                                  {img_reg[5], img_reg[4]} : {8'h00, img_reg[4]};
    assign field_count_o = 4'((img_len_reg - 5'h04
                              - (img_reg[4][`BOMC_GROUP_EXT_BIT] ? 5'h02 : 5'h01)) >> 1);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            field_select_word_o <= 16'h0000;
        end
        else if (ce_i)
        begin
            if (img_reg[4][`BOMC_GROUP_EXT_BIT])
            begin
                field_select_word_o <= {img_reg[5'd7 + {1'b0, field_rd_idx_i, 1'b0}],
                                        img_reg[5'd6 + {1'b0, field_rd_idx_i, 1'b0}]};
            end
            else
            begin
                field_select_word_o <= {img_reg[5'd6 + {1'b0, field_rd_idx_i, 1'b0}],
                                        img_reg[5'd5 + {1'b0, field_rd_idx_i, 1'b0}]};
            end
        end
    end

    bomc_rate_div u_rate_div (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .tick_i    (imu_tick_i),
        .divider_i (emit_rate_divider_o),
        .enable_i  (output_port_select_o != `BOMC_PORT_NONE),
        .emit_o    (emit_reg)
    );

    assign emit_port1_o = emit_reg && (output_port_select_o == `BOMC_PORT_ONE
                                       || output_port_select_o == `BOMC_PORT_BOTH);
    assign emit_port2_o = emit_reg && (output_port_select_o == `BOMC_PORT_TWO
                                       || output_port_select_o == `BOMC_PORT_BOTH);

endmodule

//--- pkg/bomc_map.svh
// constants for the binary output message configuration register
`ifndef BOMC_MAP_SVH
`define BOMC_MAP_SVH

`define BOMC_REG_ID          8'h4C
`define BOMC_OFS_PORT_SEL    5'h00
`define BOMC_OFS_RATE_DIV    5'h02
`define BOMC_OFS_GROUP       5'h04
`define BOMC_LEN_MIN         5'h06
`define BOMC_LEN_MAX         5'h16
`define BOMC_MAX_FIELDS      8
`define BOMC_GROUP_EXT_BIT   7
`define BOMC_PORT_NONE       16'h0000
`define BOMC_PORT_ONE        16'h0001
`define BOMC_PORT_TWO        16'h0002
`define BOMC_PORT_BOTH       16'h0003
`define BOMC_RST_PORT_SEL    16'h0000
`define BOMC_RST_RATE_DIV    16'h0010
`define BOMC_RST_GROUP       8'h00
`define BOMC_RST_LEN         5'h05
`define BOMC_IMU_RATE_HZ     24'h000320
`define BOMC_BYTES_PER_FIELD 16'h0004
`define BOMC_MSG_OVERHEAD    16'h0008

`endif

//--- pkg/bomc_pkg.sv
// types shared by the message configuration block
package bomc_pkg;

    typedef enum logic [1:0] {
        BOMC_RESP_OK,
        BOMC_RESP_INVALID_PARAM,
        BOMC_RESP_INSUFF_BAUD
    } bomc_resp_t;

    typedef enum {
        BOMC_ST_IDLE,
        BOMC_ST_RECV,
        BOMC_ST_CHECK,
        BOMC_ST_READ
    } bomc_state_t;

endpackage

//--- src/bomc_rate_div.sv
// sample-rate divider that paces message emission
module bomc_rate_div (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    // pacing
    input  wire logic        tick_i,
    input  wire logic [15:0] divider_i,
    input  wire logic        enable_i,
    output logic             emit_o
);

    logic [15:0] count_reg;

    // count samples; a zero divider never fires since writes reject it anyway
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_reg <= 16'h0000;
            emit_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            emit_o <= 1'b0;
            if (!enable_i)
            begin
                count_reg <= 16'h0000;
            end
            else if (tick_i)
            begin
                if ((count_reg + 16'h0001) >= divider_i && divider_i != 16'h0000)
                begin
                    count_reg <= 16'h0000;
                    emit_o    <= 1'b1;
                end
                else
                begin
                    count_reg <= count_reg + 16'h0001;
                end
            end
        end
    end

endmodule

//--- dv/bomc_cfg_asserts.sv
// port checker for the message configuration register block
module bomc_cfg_asserts (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // command link
    input wire logic        ce_i,
    input wire logic        wr_byte_valid_i,
    input wire logic        wr_byte_last_i,
    input wire logic        resp_valid_o,
    input wire logic        rd_byte_ready_i,
    input wire logic        rd_byte_valid_o,
    input wire logic        rd_byte_last_o,
    // emission and active configuration
    input wire logic        emit_port1_o,
    input wire logic        emit_port2_o,
    input wire logic [15:0] output_port_select_o,
    input wire logic [15:0] emit_rate_divider_o,
    input wire logic [15:0] group_select_mask_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_resp_lat;
        ce_i && wr_byte_valid_i && wr_byte_last_i |-> ##2 resp_valid_o;
    endproperty
    a_resp_lat: assert property (p_resp_lat) else $error("write answer not on time");
    property p_resp_one; resp_valid_o |=> !resp_valid_o; endproperty
    a_resp_one: assert property (p_resp_one) else $error("write answer too long");
    // config only moves on an answer
    property p_cfg_hold;
        !resp_valid_o |-> $stable(output_port_select_o) && $stable(group_select_mask_o)
                          && $stable(emit_rate_divider_o);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without answer");
    property p_div_nz; emit_rate_divider_o != 16'h0000; endproperty
    a_div_nz: assert property (p_div_nz) else $error("zero divider committed");
    property p_port_rng; output_port_select_o <= 16'h0003; endproperty
    a_port_rng: assert property (p_port_rng) else $error("port code out of range");
    property p_emit1; emit_port1_o |-> output_port_select_o[0]; endproperty
    a_emit1: assert property (p_emit1) else $error("emit on port 1 not selected");
    property p_emit2; emit_port2_o |-> output_port_select_o[1]; endproperty
    a_emit2: assert property (p_emit2) else $error("emit on port 2 not selected");
    property p_one_byte;
        !group_select_mask_o[7] |-> group_select_mask_o[15:8] == 8'h00;
    endproperty
    a_one_byte: assert property (p_one_byte) else $error("high mask byte alone");
    property p_rd_end;
        rd_byte_valid_o && rd_byte_ready_i && rd_byte_last_o |=> !rd_byte_valid_o;
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read stream runs past last byte");
endmodule

bind bomc_cfg bomc_cfg_asserts u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .wr_byte_valid_i(wr_byte_valid_i), .wr_byte_last_i(wr_byte_last_i),
    .resp_valid_o(resp_valid_o), .rd_byte_ready_i(rd_byte_ready_i),
    .rd_byte_valid_o(rd_byte_valid_o), .rd_byte_last_o(rd_byte_last_o),
    .emit_port1_o(emit_port1_o), .emit_port2_o(emit_port2_o),
    .output_port_select_o(output_port_select_o), .emit_rate_divider_o(emit_rate_divider_o),
    .group_select_mask_o(group_select_mask_o)
);

//--- dv/bomc_host.sv
// host model issuing register writes and reads on the command link
module bomc_host (
    // clock
    input  wire logic       clk_i,
    // answers from the block
    input  wire logic       resp_valid_i,
    input  wire logic [1:0] resp_code_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_byte_i,
    input  wire logic       rd_last_i,
    // requests to the block
    output logic            wr_start_o,
    output logic [7:0]      wr_id_o,
    output logic            wr_v_o,
    output logic [7:0]      wr_b_o,
    output logic            wr_l_o,
    output logic            rd_start_o,
    output logic            rd_rdy_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels at time zero
    initial
    begin
        {wr_start_o, wr_v_o, wr_l_o, rd_start_o, rd_rdy_o} = 5'h00;
        wr_id_o = 8'h00;
        wr_b_o = 8'h00;
    end

    task automatic wr(input logic [7:0] id, input int n, input logic [183:0] v,
                      output logic got, output logic [1:0] code);
        got = 1'b0;
        code = 2'h3;
        @(posedge clk_i);
        wr_start_o <= 1'b1;
        wr_id_o <= id;
        @(posedge clk_i);
        wr_start_o <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            wr_v_o <= 1'b1;
            wr_b_o <= v[8*i+:8];
            wr_l_o <= (i == n - 1);
            @(posedge clk_i);
        end
        // released data line shows the inverse so a stale byte cannot pass
        wr_v_o <= 1'b0;
        wr_l_o <= 1'b0;
        wr_b_o <= ~wr_b_o;
        repeat (4)
        begin
            @(posedge clk_i);
            #1;
            if (resp_valid_i === 1'b1)
            begin
                got = 1'b1;
                code = resp_code_i;
            end
        end
    endtask

    // read stream; slow mode stalls every other cycle
    task automatic rd(input bit slow, output int n, output logic [7:0] b [23]);
        bit fin;
        n = 0;
        fin = 1'b0;
        @(posedge clk_i);
        rd_start_o <= 1'b1;
        @(posedge clk_i);
        rd_start_o <= 1'b0;
        for (int k = 0; k < 60 && !fin; k++)
        begin
            rd_rdy_o <= slow ? k[0] : 1'b1;
            #1;
            if (rd_valid_i === 1'b1 && rd_rdy_o && n < 23)
            begin
                b[n] = rd_byte_i;
                n++;
                fin = rd_last_i;
            end
            @(posedge clk_i);
        end
        rd_rdy_o <= 1'b0;
    endtask
endmodule

//--- dv/bomc_cfg_tb.sv
// self-checking bench for the message configuration register block
module bomc_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and stimulus
    logic                 clk_i = 1'b0;
    logic                 resetn_i = 1'b0;
    logic [23:0]          baud = 24'hFFFFFF;
    logic                 tick = 1'b0;
    logic [2:0]           fidx = 3'h0;
    logic                 wr_s, wr_v, wr_l, rd_s, rd_r, resp_v, rd_v, rd_l, e1, e2, got;
    logic [7:0]           wr_id, wr_b, rd_id, rd_b;
    logic [15:0]          port, div, mask, fword;
    logic [3:0]           fcnt;
    logic [1:0]           rc;
    bomc_pkg::bomc_resp_t resp_c;
    logic [7:0]           rb [23];
    int                   fails = 0, n_tests = 0, cyc = 0, e1c = 0, e2c = 0, n;

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (e1 === 1'b1) e1c <= e1c + 1;
    always @(posedge clk_i) if (e2 === 1'b1) e2c <= e2c + 1;
    assign rd_id = 8'h4C;

    bomc_host host (.clk_i(clk_i), .resp_valid_i(resp_v), .resp_code_i(resp_c),
        .rd_valid_i(rd_v), .rd_byte_i(rd_b), .rd_last_i(rd_l), .wr_start_o(wr_s),
        .wr_id_o(wr_id), .wr_v_o(wr_v), .wr_b_o(wr_b), .wr_l_o(wr_l),
        .rd_start_o(rd_s), .rd_rdy_o(rd_r));

    bomc_cfg dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .wr_start_i(wr_s),
        .wr_reg_id_i(wr_id), .wr_byte_valid_i(wr_v), .wr_byte_i(wr_b),
        .wr_byte_last_i(wr_l), .resp_valid_o(resp_v), .resp_code_o(resp_c),
        .rd_start_i(rd_s), .rd_reg_id_i(rd_id), .rd_byte_ready_i(rd_r),
        .rd_byte_valid_o(rd_v), .rd_byte_o(rd_b), .rd_byte_last_o(rd_l),
        .baud_bytes_per_s_i(baud), .imu_tick_i(tick), .emit_port1_o(e1),
        .emit_port2_o(e2), .output_port_select_o(port), .emit_rate_divider_o(div),
        .group_select_mask_o(mask), .field_count_o(fcnt), .field_rd_idx_i(fidx),
        .field_select_word_o(fword));

    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one write of register 76 with its answer judged
    task automatic put(input int n, input logic [183:0] v, input bomc_pkg::bomc_resp_t e);
        host.wr(8'h4C, n, v, got, rc);
        chk("answer", {14'h0, rc}, {14'h0, e});
    endtask

    task automatic fw(input logic [2:0] k, input logic [15:0] e);
        @(posedge clk_i);
        fidx <= k;
        repeat (2) @(posedge clk_i);
        #1;
        chk("fword", fword, e);
    endtask

    task automatic pulse(input int k);
        repeat (k)
        begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset;
        chk("port", port, 16'h0000);
        chk("div", div, 16'h0010);
        chk("mask", mask, 16'h0000);
        chk("fcnt", {12'h0, fcnt}, 16'h0000);
        host.rd(1'b0, n, rb);
        chk("rdlen", 16'(n), 16'h0005);
        chk("rddiv", {rb[3], rb[2]}, 16'h0010);
        host.wr(8'h4B, 0, 184'h0, got, rc);
        chk("foreign id", {15'h0, got}, 16'h0000);
        $display("test reset done");
    endtask

    // every port code, divider 2, four samples each; code 0 stops output
    task automatic t_ports;
        for (int i = 0; i < 4; i++)
        begin
            put(7, {128'h0, 48'h000101000200, 8'(i)}, bomc_pkg::BOMC_RESP_OK);
            chk("port", port, 16'(i));
            e1c = 0;
            e2c = 0;
            pulse(4);
            chk("emit1", 16'(e1c), i[0] ? 16'h0002 : 16'h0000);
            chk("emit2", 16'(e2c), i[1] ? 16'h0002 : 16'h0000);
        end
        $display("test ports done");
    endtask

    task automatic t_groups;
        put(7, 184'h00010500020001, bomc_pkg::BOMC_RESP_INVALID_PARAM);
        chk("mask kept", mask, 16'h0001);
        put(9, 184'h000700030500020001, bomc_pkg::BOMC_RESP_OK);
        chk("mask", mask, 16'h0005);
        chk("fcnt", {12'h0, fcnt}, 16'h0002);
        fw(3'h1, 16'h0007);
        $display("test groups done");
    endtask

    task automatic t_two;
        logic [183:0] v;
        v = 184'h000F018000040001;
        put(8, v, bomc_pkg::BOMC_RESP_OK);
        chk("mask", mask, 16'h0180);
        fw(3'h0, 16'h000F);
        host.rd(1'b1, n, rb);
        chk("rdlen", 16'(n), 16'h0008);
        for (int i = 0; i < 8; i++)
            chk("rdbyte", {8'h00, rb[i]}, {8'h00, v[8*i+:8]});
        $display("test two bytes done");
    endtask

    task automatic t_len;
        logic [183:0] v;
        v = 184'h0100010001000100010001000100010001FF8000020000;
        put(5, 184'h0000020001, bomc_pkg::BOMC_RESP_INVALID_PARAM);
        put(6, 184'h008000020000, bomc_pkg::BOMC_RESP_OK);
        chk("mask", mask, 16'h0080);
        put(22, v, bomc_pkg::BOMC_RESP_OK);
        chk("fcnt", {12'h0, fcnt}, 16'h0008);
        put(23, v, bomc_pkg::BOMC_RESP_INVALID_PARAM);
        chk("mask kept", mask, 16'hFF80);
        $display("test length done");
    endtask

    // capacity exactly met, then exceeded by divider and by baud
    task automatic t_baud;
        @(posedge clk_i);
        baud <= 24'h0012C0;
        put(7, 184'h00010100020001, bomc_pkg::BOMC_RESP_OK);
        put(7, 184'h00010100010001, bomc_pkg::BOMC_RESP_INSUFF_BAUD);
        chk("div kept", div, 16'h0002);
        @(posedge clk_i);
        baud <= 24'h0012BF;
        put(7, 184'h00010100020001, bomc_pkg::BOMC_RESP_INSUFF_BAUD);
        $display("test baud done");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard well beyond the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            end_of_test;
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        t_reset;
        t_ports;
        t_groups;
        t_two;
        t_len;
        t_baud;
        end_of_test;
    end
endmodule
